/* bench/encoder_period_compare_tb.sv */
// Self-checking bench for the encoder period and compare block.
// Sole AHB-Lite master; the encoder model drives the pins.
`timescale 1ns/100ps
module encoder_period_compare_tb;
    logic hclk, hresetn, hsel, hwrite, enc_a, enc_b, enc_z;
    logic rd_ph = 1'b0;
    logic encoder_irq, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [31:0] exp_q[$];
    int miscompares, checks, seed;

    encoder_period_compare #(.CNT_W(16)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .enc_a(enc_a),
        .enc_b(enc_b), .enc_z(enc_z), .encoder_irq(encoder_irq));
    epc_enc_model u_enc (.hclk(hclk), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic [31:0] ra;
        // Upper address bits are random: only the low byte is decoded
        ra = $random(seed);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        haddr <= {ra[31:8], a};
        do @(posedge hclk); while (!hreadyout);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!hreadyout);
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic irq(input logic e);
        repeat (3) @(posedge hclk);
        chk("irq", {31'h0, e}, {31'h0, encoder_irq});
    endtask : irq

    // Each completed read is taken against the oldest note
    always @(posedge hclk) begin
        if (rd_ph && hreadyout)
            chk("hrdata", exp_q.pop_front(), hrdata);
        if (hreadyout)
            rd_ph <= hsel & htrans[1] & !hwrite;
    end

    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        conclude();
    end

    initial begin
        seed = 32'h838A0494;
        {hresetn, hsel, hwrite} = 3'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = $random(seed);
        hwdata = $random(seed);
        miscompares = 0;
        checks = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        bus(1'b1, 8'h18, 32'hFFFFFFFF);
        rd(8'h18, 32'h0);
        repeat (4) begin
            r = $random(seed);
            bus(1'b1, 8'h04, r);
            rd(8'h04, r & 32'h0000FFFF);
            bus(1'b1, 8'h08, r);
            rd(8'h08, r & 32'h00FFFFFF);
        end
        bus(1'b1, 8'h04, 32'h3);
        bus(1'b1, 8'h00, 32'h48);
        for (int i = 1; i <= 5; i++) begin
            u_enc.step(1'b1);
            rd(8'h0C, i % 4);
        end
        for (int i = 1; i <= 3; i++) begin
            u_enc.step(1'b0);
            rd(8'h0C, (5 - i) % 4);
        end
        rd(8'h10, 32'h4);
        for (int m = 1; m <= 3; m++) begin
            bus(1'b1, 8'h00, 32'h48 | m);
            repeat (5) u_enc.step(1'b1);
            rd(8'h0C, 32'h5);
        end
        bus(1'b1, 8'h10, 32'h7);
        bus(1'b1, 8'h08, 32'h00FF0002);
        bus(1'b1, 8'h14, 32'h1);
        bus(1'b1, 8'h00, 32'h78);
        u_enc.step(1'b1);
        irq(1'b0);
        u_enc.step(1'b1);
        irq(1'b1);
        rd(8'h10, 32'h1);
        bus(1'b1, 8'h14, 32'h0);
        irq(1'b0);
        bus(1'b1, 8'h14, 32'h1);
        irq(1'b1);
        bus(1'b1, 8'h10, 32'h1);
        irq(1'b0);
        bus(1'b1, 8'h04, 32'h4);
        bus(1'b1, 8'h00, 32'h7C);
        repeat (2) u_enc.step(1'b1);
        irq(1'b0);
        u_enc.index();
        irq(1'b1);
        rd(8'h10, 32'h3);
        rd(8'h00, 32'h3C);
        rd(8'h14, 32'h1);
        // Stopping clears match and index flags and holds the count
        bus(1'b1, 8'h00, 32'h0);
        u_enc.step(1'b1);
        rd(8'h0C, 32'h0);
        rd(8'h10, 32'h0);
        irq(1'b0);
        conclude();
    end
endmodule : encoder_period_compare_tb

/* bench/epc_enc_model.sv */
// Incremental encoder model driving the A, B and Z phases.
// Assumes the bench calls its tasks; edges stand at least 8 clocks apart.
`timescale 1ns/100ps
module epc_enc_model (
    input wire logic hclk,
    output logic enc_a,
    output logic enc_b,
    output logic enc_z
);
    logic [1:0] ph = 2'h0;
    initial enc_z = 1'b0;
    // Gray order 00,10,11,01 has A leading B when turning up
    assign enc_a = ph[1] ^ ph[0];
    assign enc_b = ph[1];
    task automatic step(input logic up);
        @(posedge hclk);
        ph <= up ? ph + 2'h1 : ph - 2'h1;
        repeat (8) @(posedge hclk);
    endtask : step
    task automatic index();
        @(posedge hclk);
        enc_z <= 1'b1;
        repeat (8) @(posedge hclk);
        enc_z <= 1'b0;
        repeat (8) @(posedge hclk);
    endtask : index
endmodule : epc_enc_model

/* bench/epc_props.sv */
// Checker for the encoder period and compare block.
// Sees only the top ports; bound to the design below.
`timescale 1ns/100ps
module epc_props #(
    parameter int CNT_W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_z,
    input wire logic encoder_irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic take;
    logic wr_ph;
    logic [3:0] quiet;
    assign take = hsel & htrans[1] & hready;
    // Cycles since a pin moved, saturating; write data phase flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet <= 4'hF;
            wr_ph <= 1'b0;
        end else begin
            if ($changed({enc_a, enc_b, enc_z}))
                quiet <= 4'h0;
            else if (quiet != 4'hF)
                quiet <= quiet + 4'h1;
            if (hready)
                wr_ph <= take & hwrite;
        end
    end
    sequence s_rd(logic [7:0] a); take && !hwrite && haddr[7:0] == a; endsequence
    sequence s_ans(logic [31:0] m); !hreadyout ##1 (hreadyout && (hrdata & m) == 32'h0); endsequence
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("error response");
    property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_wr_fast; take && hwrite |=> hreadyout; endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
    property p_period_hi; s_rd(8'h04) |=> s_ans(32'hFFFF0000); endproperty
    a_period_hi: assert property (p_period_hi) else $error("period high bits");
    property p_cmp_hi; s_rd(8'h08) |=> s_ans(32'hFF000000); endproperty
    a_cmp_hi: assert property (p_cmp_hi) else $error("compare high bits");
    property p_cnt_hi; s_rd(8'h0C) |=> s_ans(32'hFFFFFFFF << CNT_W); endproperty
    a_cnt_hi: assert property (p_cnt_hi) else $error("count too wide");
    property p_unmapped; s_rd(8'h18) |=> s_ans(32'hFFFFFFFF); endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    property p_irq_cause;
        $rose(encoder_irq) |-> quiet < 4'hC || $past(wr_ph) || $past(wr_ph, 2) || $past(wr_ph, 3);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
    property p_irq_rst; $rose(hresetn) |-> !encoder_irq; endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
endmodule : epc_props

bind encoder_period_compare epc_props #(.CNT_W(CNT_W)) u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z),
    .encoder_irq(encoder_irq));

/* logic/encoder_period_compare.sv */
// Encoder position counter with period and compare registers on AHB-Lite.
// Assumes one AHB-Lite master, whole-word single transfers, A/B/Z from pins.
// How it works
// - A 16-bit period register sets the counter period in times-four pulses.
// - Counting up, the counter reaches the period then wraps to zero.
// - Counting down, the counter reaches zero then loads the period.
// - The period only bounds the counter in encoder mode.
// - A 24-bit read-write compare value sits in bits 23 to 0.
// - In encoder mode the low 16 compare bits give the match position.
// - The count pulse comes on every A or B edge except a double change, four per cycle.
// - Match enable sets the match flag; interrupt waits for index if used.
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module encoder_period_compare #(
    parameter int CNT_W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_z,
    output logic encoder_irq
);
    if (CNT_W != epc_pkg::EPC_PERIOD_W) begin : g_bad_cnt_w
        $error("encoder_period_compare supports only a 16-bit counter");
    end

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        logic wr_pend;
        logic rd_pend;
        logic [7:0] addr;
        epc_pkg::epc_mode_t mode;
        logic z_use;
        logic run;
        logic match_en;
        logic irq_en;
        logic [CNT_W-1:0] period;
        logic [epc_pkg::EPC_COMPARE_W-1:0] compare;
        logic [CNT_W-1:0] count;
        logic [epc_pkg::EPC_ST_W-1:0] status;
        logic [epc_pkg::EPC_ST_W-1:0] mask;
        logic z_prev;
        logic irq;
    } epc_top_state_t;

    epc_top_state_t st;
    epc_top_state_t next_st;

    logic [2:0] pins_sync;
    logic quad_pulse;
    logic quad_up;

    epc_sync2 #(
        .W(3)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({enc_z, enc_b, enc_a}),
        .sync_out(pins_sync)
    );

    epc_quad_decoder u_dec (
        .hclk(hclk),
        .hresetn(hresetn),
        .phase_a(pins_sync[0]),
        .phase_b(pins_sync[1]),
        .quad_count_pulse(quad_pulse),
        .count_up(quad_up)
    );

    // Register read multiplexer
    function automatic logic [31:0] epc_read(input epc_top_state_t s, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h00000000;
        unique case (a)
            epc_pkg::EPC_OFS_CTRL: begin
                d[epc_pkg::EPC_CTRL_MODE_LSB +: 2] = s.mode;
                d[epc_pkg::EPC_CTRL_ZUSE] = s.z_use;
                d[epc_pkg::EPC_CTRL_RUN] = s.run;
                d[epc_pkg::EPC_CTRL_MATCH_EN] = s.match_en;
                d[epc_pkg::EPC_CTRL_IRQ_EN] = s.irq_en;
            end
            epc_pkg::EPC_OFS_PERIOD: begin
                d[CNT_W-1:0] = s.period;
            end
            epc_pkg::EPC_OFS_COMPARE: begin
                d[epc_pkg::EPC_COMPARE_W-1:0] = s.compare;
            end
            epc_pkg::EPC_OFS_COUNT: begin
                d[CNT_W-1:0] = s.count;
            end
            epc_pkg::EPC_OFS_STATUS: begin
                d[epc_pkg::EPC_ST_W-1:0] = s.status;
            end
            epc_pkg::EPC_OFS_MASK: begin
                d[epc_pkg::EPC_ST_W-1:0] = s.mask;
            end
            default: begin
                d = 32'h00000000;
            end
        endcase
        return d;
    endfunction : epc_read

    logic take;
    logic do_write;
    logic sw_clear;
    logic [epc_pkg::EPC_ST_W-1:0] st_w1c;
    logic [epc_pkg::EPC_ST_W-1:0] events;
    logic enc_mode;
    logic z_now;
    logic z_hit;
    logic stepped;
    logic [CNT_W-1:0] new_count;

    always_comb begin
        next_st = st;
        take = hsel && htrans[1] && hready;
        do_write = st.wr_pend && st.hreadyout;
        sw_clear = 1'b0;
        st_w1c = '0;
        events = '0;
        enc_mode = (st.mode == epc_pkg::EPC_MODE_ENCODER);
        z_now = pins_sync[2];
        z_hit = 1'b0;
        stepped = 1'b0;
        new_count = st.count;
        next_st.z_prev = z_now;
        next_st.hresp = 1'b0;

        // Bus data phase: writes complete in zero wait, reads take one wait
        if (st.rd_pend) begin
            next_st.hrdata = epc_read(st, st.addr);
            next_st.hreadyout = 1'b1;
            next_st.rd_pend = 1'b0;
        end
        if (do_write) begin
            next_st.wr_pend = 1'b0;
            unique case (st.addr)
                epc_pkg::EPC_OFS_CTRL: begin
                    next_st.mode = epc_pkg::epc_mode_t'(hwdata[epc_pkg::EPC_CTRL_MODE_LSB +: 2]);
                    next_st.z_use = hwdata[epc_pkg::EPC_CTRL_ZUSE];
                    next_st.run = hwdata[epc_pkg::EPC_CTRL_RUN];
                    next_st.match_en = hwdata[epc_pkg::EPC_CTRL_MATCH_EN];
                    next_st.irq_en = hwdata[epc_pkg::EPC_CTRL_IRQ_EN];
                    sw_clear = hwdata[epc_pkg::EPC_CTRL_CLEAR];
                end
                epc_pkg::EPC_OFS_PERIOD: begin
                    next_st.period = hwdata[CNT_W-1:0];
                end
                epc_pkg::EPC_OFS_COMPARE: begin
                    next_st.compare = hwdata[epc_pkg::EPC_COMPARE_W-1:0];
                end
                epc_pkg::EPC_OFS_STATUS: begin
                    st_w1c = hwdata[epc_pkg::EPC_ST_W-1:0];
                end
                epc_pkg::EPC_OFS_MASK: begin
                    next_st.mask = hwdata[epc_pkg::EPC_ST_W-1:0];
                end
                default: begin
                    sw_clear = 1'b0;
                end
            endcase
        end
        if (take) begin
            next_st.addr = haddr[7:0];
            next_st.wr_pend = hwrite;
            next_st.rd_pend = !hwrite;
            next_st.hreadyout = hwrite;
        end

        // Index edge in the counting direction clears the counter first
        if (st.run && enc_mode && st.z_use) begin
            z_hit = (quad_up && z_now && !st.z_prev) || (!quad_up && !z_now && st.z_prev);
        end
        if (z_hit) begin
            new_count = '0;
            stepped = 1'b1;
            events[epc_pkg::EPC_ST_INDEX] = 1'b1;
        end else if (st.run && quad_pulse) begin
            stepped = 1'b1;
            if (quad_up) begin
                if (enc_mode && (st.count == st.period)) begin
                    new_count = '0;
                    events[epc_pkg::EPC_ST_WRAP] = 1'b1;
                end else begin
                    new_count = st.count + 1'b1;
                end
            end else begin
                if (enc_mode && (st.count == '0)) begin
                    new_count = st.period;
                    events[epc_pkg::EPC_ST_WRAP] = 1'b1;
                end else begin
                    new_count = st.count - 1'b1;
                end
            end
        end
        if (sw_clear) begin
            new_count = '0;
        end
        next_st.count = new_count;

        // Match on the low 16 compare bits in encoder mode
        if (stepped && st.match_en && enc_mode &&
            (new_count == st.compare[epc_pkg::EPC_POS_CMP_W-1:0])) begin
            events[epc_pkg::EPC_ST_MATCH] = 1'b1;
        end

        // Sticky flags: a new event beats a clear in the same cycle
        next_st.status = (st.status & ~st_w1c) | events;
        if (!st.run) begin
            next_st.status[epc_pkg::EPC_ST_MATCH] = 1'b0;
            next_st.status[epc_pkg::EPC_ST_INDEX] = 1'b0;
        end

        // Interrupt held back until the index has been seen when in use
        next_st.irq = st.irq_en && (|(next_st.status & next_st.mask)) &&
            (!st.z_use || next_st.status[epc_pkg::EPC_ST_INDEX]);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            st.hreadyout <= 1'b1;
            st.mode <= epc_pkg::EPC_MODE_ENCODER;
            st.period <= epc_pkg::EPC_PERIOD_RST;
            st.compare <= epc_pkg::EPC_COMPARE_RST;
            st.status <= epc_pkg::EPC_STATUS_RST;
            st.mask <= epc_pkg::EPC_MASK_RST;
        end else begin
            st <= next_st;
        end
    end

    assign hrdata = st.hrdata;
    assign hreadyout = st.hreadyout;
    assign hresp = st.hresp;
    assign encoder_irq = st.irq;
endmodule : encoder_period_compare

/* logic/epc_pkg.sv */
// Package for the encoder period and compare block.
// Holds register offsets, field positions, reset values and mode codes.
// Assumes a 32-bit AHB-Lite bus with one aligned word per register.
package epc_pkg;

    // Register byte offsets
    localparam logic [7:0] EPC_OFS_CTRL = 8'h00;
    localparam logic [7:0] EPC_OFS_PERIOD = 8'h04;
    localparam logic [7:0] EPC_OFS_COMPARE = 8'h08;
    localparam logic [7:0] EPC_OFS_COUNT = 8'h0C;
    localparam logic [7:0] EPC_OFS_STATUS = 8'h10;
    localparam logic [7:0] EPC_OFS_MASK = 8'h14;

    // Control register fields
    localparam int EPC_CTRL_MODE_LSB = 0;
    localparam int EPC_CTRL_ZUSE = 2;
    localparam int EPC_CTRL_RUN = 3;
    localparam int EPC_CTRL_MATCH_EN = 4;
    localparam int EPC_CTRL_IRQ_EN = 5;
    localparam int EPC_CTRL_CLEAR = 6;

    // Status and mask register fields
    localparam int EPC_ST_MATCH = 0;
    localparam int EPC_ST_INDEX = 1;
    localparam int EPC_ST_WRAP = 2;
    localparam int EPC_ST_W = 3;

    // Field widths
    localparam int EPC_PERIOD_W = 16;
    localparam int EPC_COMPARE_W = 24;
    localparam int EPC_POS_CMP_W = 16;

    // Reset values
    localparam logic [15:0] EPC_PERIOD_RST = 16'h0000;
    localparam logic [23:0] EPC_COMPARE_RST = 24'h000000;
    localparam logic [2:0] EPC_STATUS_RST = 3'h0;
    localparam logic [2:0] EPC_MASK_RST = 3'h0;

    // Operating modes
    typedef enum logic [1:0] {
        EPC_MODE_ENCODER = 2'h0,
        EPC_MODE_SENSOR_EVENT = 2'h1,
        EPC_MODE_SENSOR_TIMER = 2'h2,
        EPC_MODE_TIMER = 2'h3
    } epc_mode_t;

endpackage : epc_pkg

/* logic/epc_quad_decoder.sv */
// Quadrature decoder producing the times-four count pulse and direction.
// Assumes synchronised A and B phases; a double change is dropped.
`timescale 1ns/100ps
module epc_quad_decoder (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic phase_a,
    input wire logic phase_b,
    output logic quad_count_pulse,
    output logic count_up
);
    typedef struct packed {
        logic a_q;
        logic b_q;
        logic pulse;
        logic up;
    } epc_dec_state_t;

    epc_dec_state_t st;
    epc_dec_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.a_q = phase_a;
        next_st.b_q = phase_b;
        // One pulse on an edge of A or B alone, none when both change together
        next_st.pulse = (phase_a ^ st.a_q) ^ (phase_b ^ st.b_q);
        if ((phase_a ^ st.a_q) ^ (phase_b ^ st.b_q)) begin
            // A leading B counts up
            next_st.up = phase_a ^ st.b_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign quad_count_pulse = st.pulse;
    assign count_up = st.up;
endmodule : epc_quad_decoder

/* logic/epc_sync2.sv */
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to hclk; only the second flop is read.
`timescale 1ns/100ps
module epc_sync2 #(
    parameter int W = 3
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } epc_sync_state_t;

    epc_sync_state_t st;
    epc_sync_state_t next_st;

    if (W < 1) begin : g_bad_width
        $error("epc_sync2 needs W of at least 1");
    end

    always_comb begin
        next_st = st;
        next_st.s1 = async_in;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.s2;
endmodule : epc_sync2
